// file: inc/dsp_decode_regs.svh
// register offsets, field positions, reset values, opcode patterns and cycle counts
`ifndef DSP_DECODE_REGS_SVH
`define DSP_DECODE_REGS_SVH
// ----------------------------------------------------------------
// apb byte offsets
// ----------------------------------------------------------------
`define OFS_OPCODE 8'h00
`define OFS_SRC 8'h04
`define OFS_DST 8'h08
`define OFS_PC 8'h0C
`define OFS_VBASE 8'h10
`define OFS_MEMRD 8'h14
`define OFS_IDXX 8'h18
`define OFS_IDXY 8'h1C
`define OFS_STALL 8'h20
`define OFS_STATUS 8'h24
`define OFS_FILE 8'h28
`define OFS_FILE_END 8'h48
`define OFS_RESULT 8'h4C
`define OFS_PTR_OUT 8'h50
`define OFS_MEM_ADDR 8'h54
`define OFS_MEM_WDATA 8'h58
`define OFS_NEW_PC 8'h5C
`define OFS_INFO 8'h60
`define OFS_YADDR 8'h64
`define OFS_YPTR_OUT 8'h68
// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define SR_CNT_HI 27
`define SR_CNT_LO 16
`define SR_FLAG_HI 3
`define SR_FLAG_LO 2
`define SR_TBIT 0
`define SR_RESET 32'h000000F0
// ----------------------------------------------------------------
// x/y memory windows
// ----------------------------------------------------------------
`define XY_MASK 32'hFFFF0000
`define XMEM_BASE 32'h10000000
`define YMEM_BASE 32'h10010000
// ----------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------
`define OP_LDC_REG 16'b0100_????_????_1110
`define OP_LDC_MEM 16'b0100_????_????_0111
`define OP_STC_REG 16'b0000_????_????_0010
`define OP_STC_MEM 16'b0100_????_????_0011
`define OP_LDS_REG 16'b0100_????_????_1010
`define OP_LDS_MEM 16'b0100_????_????_0110
`define OP_STS_REG 16'b0000_????_????_1010
`define OP_STS_MEM 16'b0100_????_????_0010
`define OP_SET_LOOP_COUNT_OP_REG 16'b0100_????_0001_0100
`define OP_SET_LOOP_COUNT_OP_IMM 16'b1000_0010_????_????
`define OP_LOAD_LOOP_HEAD_OP 16'b1000_1100_????_????
`define OP_LOAD_LOOP_END_OP 16'b1000_1110_????_????
`define OP_TRAP 16'b1100_0011_????_????
`define OP_DOUBLE 16'b1111_00??_????_????
`define OP_SINGLE 16'b1111_01??_????_????
`define PAR_PREFIX 6'b111110
// ----------------------------------------------------------------
// minimum cycle counts
// ----------------------------------------------------------------
`define CYC_ONE 4'h1
`define CYC_CTRL_LOAD 4'h3
`define CYC_CTRL_SAVE 4'h2
`define CYC_TRAP 4'h6
`endif

// file: inc/dsp_decode_pkg.sv
// types shared by the decoder and the executing top
package dsp_decode_pkg;
  typedef enum logic [4:0] {
    CL_ILLEGAL, CL_LDC_REG, CL_LDC_MEM, CL_STC_REG, CL_STC_MEM,
    CL_LDS_REG, CL_LDS_MEM, CL_STS_REG, CL_STS_MEM, CL_SET_LOOP_COUNT_OP_REG,
    CL_SET_LOOP_COUNT_OP_IMM, CL_LOAD_LOOP_HEAD_OP, CL_LOAD_LOOP_END_OP, CL_TRAP, CL_DOUBLE, CL_SINGLE
  } op_class_t;
  // order fixes the index into the register file
  typedef enum logic [3:0] {
    TG_MOD, TG_RE, TG_RS, TG_DSR, TG_A0, TG_X0, TG_X1, TG_Y0, TG_Y1
  } target_t;
  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} state_t;
endpackage

// file: inc/decode_if.sv
// decoder-to-executer carrier
`timescale 1ns/100ps
interface decode_if;
  logic [31:0] opcode;
  dsp_decode_pkg::op_class_t cls;
  dsp_decode_pkg::target_t tgt;
  logic [3:0] cycles;
  logic len32;
  modport dec (input opcode, output cls, output tgt, output cycles, output len32);
  modport exec (output opcode, input cls, input tgt, input cycles, input len32);
endinterface

// file: design/dsp_op_decoder.sv
// opcode classifier: class, target register, length and minimum cycle count
`timescale 1ns/100ps
`include "dsp_decode_regs.svh"
module dsp_op_decoder (
  decode_if.dec d
);
  logic [3:0] nib;
  logic ctrl_ok;
  logic sys_ok;
  dsp_decode_pkg::target_t ctrl_tgt;
  dsp_decode_pkg::target_t sys_tgt;

  assign nib = d.opcode[7:4];
  assign ctrl_ok = (nib == 4'h5) || (nib == 4'h6) || (nib == 4'h7);
  assign sys_ok = (nib >= 4'h6) && (nib <= 4'hB);
  assign ctrl_tgt = (nib == 4'h5) ? dsp_decode_pkg::TG_MOD :
                    (nib == 4'h7) ? dsp_decode_pkg::TG_RE : dsp_decode_pkg::TG_RS;
  assign sys_tgt = dsp_decode_pkg::target_t'(nib - 4'h3);

  always_comb begin
    d.cls = dsp_decode_pkg::CL_ILLEGAL; // RULE22
    d.tgt = dsp_decode_pkg::TG_MOD;
    d.cycles = `CYC_ONE;
    d.len32 = 1'b0;
    if (d.opcode[31:26] == `PAR_PREFIX) begin
      d.cls = dsp_decode_pkg::CL_DOUBLE; // RULE15
      d.len32 = 1'b1;
    end else if (d.opcode[31:16] == 16'h0000) begin // RULE16
      casez (d.opcode[15:0])
        `OP_SET_LOOP_COUNT_OP_REG: d.cls = dsp_decode_pkg::CL_SET_LOOP_COUNT_OP_REG; // RULE6
        `OP_SET_LOOP_COUNT_OP_IMM: d.cls = dsp_decode_pkg::CL_SET_LOOP_COUNT_OP_IMM;
        `OP_LOAD_LOOP_HEAD_OP: d.cls = dsp_decode_pkg::CL_LOAD_LOOP_HEAD_OP;
        `OP_LOAD_LOOP_END_OP: d.cls = dsp_decode_pkg::CL_LOAD_LOOP_END_OP;
        `OP_TRAP: begin
          d.cls = dsp_decode_pkg::CL_TRAP;
          d.cycles = `CYC_TRAP; // RULE13
        end
        `OP_DOUBLE: d.cls = dsp_decode_pkg::CL_DOUBLE; // RULE21
        `OP_SINGLE: d.cls = dsp_decode_pkg::CL_SINGLE; // RULE21
        `OP_LDC_REG: begin
          d.cls = ctrl_ok ? dsp_decode_pkg::CL_LDC_REG : dsp_decode_pkg::CL_ILLEGAL; // RULE8
          d.tgt = ctrl_tgt;
        end
        `OP_LDC_MEM: begin
          d.cls = ctrl_ok ? dsp_decode_pkg::CL_LDC_MEM : dsp_decode_pkg::CL_ILLEGAL;
          d.tgt = ctrl_tgt;
          d.cycles = `CYC_CTRL_LOAD; // RULE9
        end
        `OP_STC_REG: begin
          d.cls = ctrl_ok ? dsp_decode_pkg::CL_STC_REG : dsp_decode_pkg::CL_ILLEGAL; // RULE11
          d.tgt = ctrl_tgt;
        end
        `OP_STC_MEM: begin
          d.cls = ctrl_ok ? dsp_decode_pkg::CL_STC_MEM : dsp_decode_pkg::CL_ILLEGAL;
          d.tgt = ctrl_tgt;
          d.cycles = `CYC_CTRL_SAVE; // RULE10
        end
        `OP_LDS_REG: begin
          d.cls = sys_ok ? dsp_decode_pkg::CL_LDS_REG : dsp_decode_pkg::CL_ILLEGAL; // RULE2
          d.tgt = sys_tgt;
        end
        `OP_LDS_MEM: begin
          d.cls = sys_ok ? dsp_decode_pkg::CL_LDS_MEM : dsp_decode_pkg::CL_ILLEGAL;
          d.tgt = sys_tgt;
        end
        `OP_STS_REG: begin
          d.cls = sys_ok ? dsp_decode_pkg::CL_STS_REG : dsp_decode_pkg::CL_ILLEGAL; // RULE12
          d.tgt = sys_tgt;
        end
        `OP_STS_MEM: begin
          d.cls = sys_ok ? dsp_decode_pkg::CL_STS_MEM : dsp_decode_pkg::CL_ILLEGAL;
          d.tgt = sys_tgt;
        end
        default: d.cls = dsp_decode_pkg::CL_ILLEGAL; // RULE22
      endcase
    end
  end
endmodule

// file: design/dsp_support_instr_decode.sv
// apb-driven execute unit for the dsp support instructions
// Behaviour
// RULE1: modulo start, end and size registers exist; loop count lives in status word.
// RULE2: load/save of the modulo registers and the six dsp system registers.
// RULE3: loop count is status word bits 16..27, written by set-loop-count.
// RULE4: immediate set-loop-count puts imm in bits 16..23, clears 24..27.
// RULE5: register set-loop-count copies source low 12 bits into bits 16..27.
// RULE6: set-loop-count also updates both repeat flags; register form one cycle.
// RULE7: loop head/end loads write pc plus twice displacement, one cycle.
// RULE8: register-to-control transfers take one cycle and keep T unchanged.
// RULE9: post-increment modulo load reads at pointer, pointer plus 4, 3 cycles.
// RULE10: pre-decrement modulo store: pointer minus 4, write there, 2 cycles.
// RULE11: modulo size copy to a general register takes one cycle.
// RULE12: dsp status copy to a general register takes one cycle, T kept.
// RULE13: trap pushes pc and status, branches via imm*4 plus vector base, 6 cycles.
// RULE14: counts are minimums; contention, load-use and 4n+2 targets add cycles.
// RULE15: parallel instructions are 32 bits carrying a double transfer.
// RULE16: standalone double and all single transfers are 16 bits.
// RULE17: double transfer accesses X and Y memory together, each side may idle.
// RULE18: X side uses the X pointer, Y side the Y pointer.
// RULE19: double transfers only reach X/Y memory; single reach any area.
// RULE20: single transfers pick one pointer from X pointers plus two more registers.
// RULE21: double group four types, 14 instructions; single group 16 instructions.
// RULE22: unmatched opcodes are flagged illegal and not executed.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "dsp_decode_regs.svh"
module dsp_support_instr_decode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dsp_decode_pkg::state_t state_q;
  dsp_decode_pkg::op_class_t cls_q;
  dsp_decode_pkg::target_t tgt_q;
  logic [31:0] op_q, src_q, dst_q, pc_q, vbase_q, memrd_q, idxx_q, idxy_q;
  logic [1:0] stall_q;
  logic [31:0] status_word_q;
  logic [31:0] file_q [0:8];
  logic [31:0] result_q, ptr_out_q, mem_addr_q, mem_wdata_q, new_pc_q;
  logic [31:0] yaddr_q, yptr_out_q;
  logic [3:0] cnt_q, cyc_q;
  logic illegal_q, len32_q, gpr_we_q, ptr_we_q, mem_rd_q, mem_wr_q;
  logic area_err_q, xact_q, yact_q;
  logic [1:0] ptr_sel_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  decode_if dif ();

  logic wr, rd_setup, start, commit, mapped;
  logic [31:0] rd_mux;
  logic [3:0] extra;
  logic [3:0] fidx;
  logic [11:0] new_cnt;
  logic [1:0] new_flags;
  logic [31:0] disp2, step, sptr_next, sptr_addr, xnext, ynext;
  logic [15:0] o;

  assign dif.opcode = pwdata;
  dsp_op_decoder u_dec (.d(dif));

  assign wr = psel & penable & pready_q & pwrite;
  assign rd_setup = psel & ~penable;
  assign start = wr && (paddr == `OFS_OPCODE) && (state_q == dsp_decode_pkg::ST_IDLE);
  assign commit = (state_q == dsp_decode_pkg::ST_EXEC) && (cnt_q == 4'h1);
  assign fidx = 4'((paddr - `OFS_FILE) >> 2);
  assign o = op_q[15:0];

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_YPTR_OUT);
  always_comb begin
    rd_mux = 32'h00000000;
    if (paddr >= `OFS_FILE && paddr <= `OFS_FILE_END) begin
      rd_mux = file_q[fidx];
    end else begin
      case (paddr)
        `OFS_OPCODE: rd_mux = op_q;
        `OFS_SRC: rd_mux = src_q;
        `OFS_DST: rd_mux = dst_q;
        `OFS_PC: rd_mux = pc_q;
        `OFS_VBASE: rd_mux = vbase_q;
        `OFS_MEMRD: rd_mux = memrd_q;
        `OFS_IDXX: rd_mux = idxx_q;
        `OFS_IDXY: rd_mux = idxy_q;
        `OFS_STALL: rd_mux = {30'h0, stall_q};
        `OFS_STATUS: rd_mux = status_word_q;
        `OFS_RESULT: rd_mux = result_q;
        `OFS_PTR_OUT: rd_mux = ptr_out_q;
        `OFS_MEM_ADDR: rd_mux = mem_addr_q;
        `OFS_MEM_WDATA: rd_mux = mem_wdata_q;
        `OFS_NEW_PC: rd_mux = new_pc_q;
        `OFS_INFO: rd_mux = {14'h0, ptr_sel_q, cyc_q, 2'b00, yact_q, xact_q, area_err_q,
                             len32_q, mem_wr_q, mem_rd_q, ptr_we_q, gpr_we_q, illegal_q,
                             state_q == dsp_decode_pkg::ST_EXEC};
        `OFS_YADDR: rd_mux = yaddr_q;
        `OFS_YPTR_OUT: rd_mux = yptr_out_q;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= rd_setup;
      pslverr_q <= rd_setup & ~mapped;
      if (rd_setup) begin
        prdata_q <= (mapped && !pwrite) ? rd_mux : 32'h00000000;
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // operand registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 32'h00000000;
      dst_q <= 32'h00000000;
      pc_q <= 32'h00000000;
      vbase_q <= 32'h00000000;
      memrd_q <= 32'h00000000;
      idxx_q <= 32'h00000000;
      idxy_q <= 32'h00000000;
      stall_q <= 2'b00;
    end else if (wr) begin
      case (paddr)
        `OFS_SRC: src_q <= pwdata;
        `OFS_DST: dst_q <= pwdata;
        `OFS_PC: pc_q <= pwdata;
        `OFS_VBASE: vbase_q <= pwdata;
        `OFS_MEMRD: memrd_q <= pwdata;
        `OFS_IDXX: idxx_q <= pwdata;
        `OFS_IDXY: idxy_q <= pwdata;
        `OFS_STALL: stall_q <= pwdata[1:0];
        default: stall_q <= stall_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer: minimum count plus stretch cycles
  // ----------------------------------------------------------------
  // trap target is the fetched vector, already in memrd_q at start
  always_comb begin
    extra = {3'b000, stall_q[0]}; // RULE14
    if (stall_q[1] && (dif.cls == dsp_decode_pkg::CL_LDC_MEM ||
                       dif.cls == dsp_decode_pkg::CL_LDS_MEM)) begin
      extra = extra + 4'h1; // RULE14
    end
    if (dif.cls == dsp_decode_pkg::CL_TRAP && memrd_q[1:0] == 2'b10) begin
      extra = extra + 4'h1; // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dsp_decode_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      cyc_q <= 4'h0;
      op_q <= 32'h00000000;
      cls_q <= dsp_decode_pkg::CL_ILLEGAL;
      tgt_q <= dsp_decode_pkg::TG_MOD;
      len32_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      case (state_q)
        dsp_decode_pkg::ST_IDLE: begin
          if (start) begin
            state_q <= dsp_decode_pkg::ST_EXEC;
            cnt_q <= dif.cycles + extra;
            cyc_q <= dif.cycles + extra;
            op_q <= pwdata;
            cls_q <= dif.cls;
            tgt_q <= dif.tgt;
            len32_q <= dif.len32;
            illegal_q <= (dif.cls == dsp_decode_pkg::CL_ILLEGAL); // RULE22
          end
        end
        dsp_decode_pkg::ST_EXEC: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            state_q <= dsp_decode_pkg::ST_IDLE;
          end
        end
        default: state_q <= dsp_decode_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // execute datapath
  // ----------------------------------------------------------------
  assign new_cnt = (cls_q == dsp_decode_pkg::CL_SET_LOOP_COUNT_OP_IMM) ?
                   {4'h0, o[7:0]} : src_q[11:0]; // RULE4 RULE5
  assign new_flags = (new_cnt > 12'h002) ? 2'b11 : new_cnt[1:0]; // RULE6
  assign disp2 = {{23{o[7]}}, o[7:0], 1'b0};
  assign step = o[1] ? 32'h00000004 : 32'h00000002;
  assign sptr_next = (o[3:2] == 2'b00) ? src_q - step :
                     (o[3:2] == 2'b01) ? src_q :
                     (o[3:2] == 2'b10) ? src_q + step : src_q + idxx_q;
  assign sptr_addr = (o[3:2] == 2'b00) ? sptr_next : src_q;
  // double transfer field A sits in the high half of a parallel opcode
  logic [15:0] fa;
  assign fa = len32_q ? op_q[31:16] : o;
  assign xnext = (fa[3:2] == 2'b10) ? src_q + 32'h00000002 :
                 (fa[3:2] == 2'b11) ? src_q + idxx_q : src_q;
  assign ynext = (fa[1:0] == 2'b10) ? dst_q + 32'h00000002 :
                 (fa[1:0] == 2'b11) ? dst_q + idxy_q : dst_q;

  // status word: set-loop-count wins over a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word_q <= `SR_RESET;
    end else if (commit && (cls_q == dsp_decode_pkg::CL_SET_LOOP_COUNT_OP_REG ||
                            cls_q == dsp_decode_pkg::CL_SET_LOOP_COUNT_OP_IMM)) begin
      status_word_q[`SR_CNT_HI:`SR_CNT_LO] <= new_cnt; // RULE3 RULE4 RULE5
      status_word_q[`SR_FLAG_HI:`SR_FLAG_LO] <= new_flags; // RULE6
    end else if (wr && paddr == `OFS_STATUS) begin
      status_word_q <= pwdata;
    end
  end

  // modulo and dsp register file; instruction writes win over software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 9; i++) begin
        file_q[i] <= 32'h00000000; // RULE1
      end
    end else if (commit && (cls_q == dsp_decode_pkg::CL_LDC_REG ||
                            cls_q == dsp_decode_pkg::CL_LDS_REG)) begin
      file_q[tgt_q] <= src_q; // RULE2 RULE8
    end else if (commit && (cls_q == dsp_decode_pkg::CL_LDC_MEM ||
                            cls_q == dsp_decode_pkg::CL_LDS_MEM)) begin
      file_q[tgt_q] <= memrd_q; // RULE9
    end else if (commit && cls_q == dsp_decode_pkg::CL_LOAD_LOOP_HEAD_OP) begin
      file_q[dsp_decode_pkg::TG_RS] <= pc_q + disp2; // RULE7
    end else if (commit && cls_q == dsp_decode_pkg::CL_LOAD_LOOP_END_OP) begin
      file_q[dsp_decode_pkg::TG_RE] <= pc_q + disp2; // RULE7
    end else if (wr && paddr >= `OFS_FILE && paddr <= `OFS_FILE_END) begin
      file_q[fidx] <= pwdata;
    end
  end

  // results handed back to the core: gpr value, pointer, memory access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 32'h00000000;
      ptr_out_q <= 32'h00000000;
      mem_addr_q <= 32'h00000000;
      mem_wdata_q <= 32'h00000000;
      new_pc_q <= 32'h00000000;
      yaddr_q <= 32'h00000000;
      yptr_out_q <= 32'h00000000;
      {gpr_we_q, ptr_we_q, mem_rd_q, mem_wr_q} <= 4'h0;
      {area_err_q, xact_q, yact_q} <= 3'b000;
      ptr_sel_q <= 2'b00;
    end else if (commit) begin
      {gpr_we_q, ptr_we_q, mem_rd_q, mem_wr_q} <= 4'h0;
      {area_err_q, xact_q, yact_q} <= 3'b000;
      case (cls_q)
        dsp_decode_pkg::CL_STC_REG, dsp_decode_pkg::CL_STS_REG: begin
          result_q <= file_q[tgt_q]; // RULE11 RULE12
          gpr_we_q <= 1'b1;
        end
        dsp_decode_pkg::CL_LDC_MEM, dsp_decode_pkg::CL_LDS_MEM: begin
          mem_addr_q <= src_q; // RULE9
          ptr_out_q <= src_q + 32'h00000004; // RULE9
          {ptr_we_q, mem_rd_q} <= 2'b11;
        end
        dsp_decode_pkg::CL_STC_MEM, dsp_decode_pkg::CL_STS_MEM: begin
          mem_addr_q <= dst_q - 32'h00000004; // RULE10
          ptr_out_q <= dst_q - 32'h00000004; // RULE10
          mem_wdata_q <= file_q[tgt_q];
          {ptr_we_q, mem_wr_q} <= 2'b11;
        end
        dsp_decode_pkg::CL_TRAP: begin
          // last push is the status word; stack grows down by two words
          ptr_out_q <= dst_q - 32'h00000008; // RULE13
          mem_wdata_q <= status_word_q;
          mem_addr_q <= vbase_q + {22'h0, o[7:0], 2'b00}; // RULE13
          new_pc_q <= memrd_q; // RULE13
          {ptr_we_q, mem_wr_q, mem_rd_q} <= 3'b111;
        end
        dsp_decode_pkg::CL_DOUBLE: begin
          xact_q <= (fa[3:2] != 2'b00); // RULE17
          yact_q <= (fa[1:0] != 2'b00); // RULE17
          mem_addr_q <= src_q; // RULE18
          yaddr_q <= dst_q; // RULE18
          ptr_out_q <= xnext;
          yptr_out_q <= ynext;
          ptr_sel_q <= {1'b0, fa[9]};
          area_err_q <= ((fa[3:2] != 2'b00) && ((src_q & `XY_MASK) != `XMEM_BASE)) ||
                        ((fa[1:0] != 2'b00) && ((dst_q & `XY_MASK) != `YMEM_BASE)); // RULE19
        end
        dsp_decode_pkg::CL_SINGLE: begin
          mem_addr_q <= sptr_addr; // RULE19
          ptr_out_q <= sptr_next;
          ptr_sel_q <= o[9:8]; // RULE20
          ptr_we_q <= 1'b1;
          mem_rd_q <= ~o[0];
          mem_wr_q <= o[0];
        end
        default: result_q <= result_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence start_s(dsp_decode_pkg::op_class_t c);
    start && dif.cls == c && stall_q == 2'b00;
  endsequence
  sequence busy_for3_s;
    (state_q == dsp_decode_pkg::ST_EXEC)[*3] ##1 (state_q == dsp_decode_pkg::ST_IDLE);
  endsequence

  set_loop_count_op_imm_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    commit && cls_q == dsp_decode_pkg::CL_SET_LOOP_COUNT_OP_IMM |=>
    status_word_q[27:24] == 4'h0 && status_word_q[23:16] == $past(o[7:0]))
    else $error("immediate loop count not placed");
  set_loop_count_op_reg_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    commit && cls_q == dsp_decode_pkg::CL_SET_LOOP_COUNT_OP_REG |=>
    status_word_q[27:16] == $past(src_q[11:0]))
    else $error("register loop count not placed");
  loop_head_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    start_s(dsp_decode_pkg::CL_LOAD_LOOP_HEAD_OP) ##1 1'b1 |=>
    file_q[dsp_decode_pkg::TG_RS] == $past(pc_q) + $past(disp2))
    else $error("loop head address wrong");
  ctrl_load_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    start_s(dsp_decode_pkg::CL_LDC_MEM) |=> busy_for3_s ##0 ptr_out_q == $past(src_q, 4) + 32'h4)
    else $error("modulo load timing or pointer wrong");
  ctrl_save_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    start_s(dsp_decode_pkg::CL_STC_MEM) |=> (state_q == dsp_decode_pkg::ST_EXEC)[*2]
    ##1 state_q == dsp_decode_pkg::ST_IDLE && mem_addr_q == dst_q - 32'h4)
    else $error("modulo store timing or address wrong");
  trap_len_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    start_s(dsp_decode_pkg::CL_TRAP) && memrd_q[1:0] != 2'b10 |=>
    (state_q == dsp_decode_pkg::ST_EXEC)[*6] ##1 state_q == dsp_decode_pkg::ST_IDLE)
    else $error("trap does not take six cycles");
  tbit_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    !(wr && paddr == `OFS_STATUS) |=> $stable(status_word_q[`SR_TBIT]))
    else $error("T flag changed by an instruction");
  single_cycle_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    start_s(dsp_decode_pkg::CL_STS_REG) |=> commit ##1 state_q == dsp_decode_pkg::ST_IDLE)
    else $error("register copy is not one cycle");
  illegal_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
    start && dif.cls == dsp_decode_pkg::CL_ILLEGAL |=> illegal_q ##1 !gpr_we_q && !ptr_we_q)
    else $error("undefined opcode executed");
endmodule

// file: tb/xy_mem_model.sv
// behavioural data memory standing behind the executer's memory ports
`timescale 1ns/100ps
module xy_mem_model (
  input wire logic [31:0] addr,
  output logic [31:0] data
);
  // low bits kept 00 so a fetched vector never lands on a 4n+2 target
  assign data = {addr[15:0], 16'hA5C4};
endmodule

// file: tb/tb_top.sv
// apb-driven self-checking bench for the dsp support instruction executer
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, maddr = 32'h0, prdata, r, mem_q;
  logic pready, pslverr, err;
  int failures = 0, compares = 0;
  dsp_support_instr_decode i_dsp_support_instr_decode (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  xy_mem_model i_xy_mem_model (.addr(maddr), .data(mem_q));
  initial begin
    forever #25 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("counts failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin failures++; conclude(); end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // busy is polled, never counted: stalls may stretch any instruction
  task ex(input logic [31:0] op, input logic [3:0] cyc);
    int n;
    n = 0;
    apb(1'b1, 8'h00, op);
    do begin apb(1'b0, 8'h60, 32'h0); n++; end while (r[0] !== 1'b0 && n < 20);
    if (n == 20) begin failures++; conclude(); end
    chk(32'(r[15:12]), 32'(cyc));
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h24, 32'h000000F0);
    apb(1'b1, 8'h24, 32'h0F000000);
    ex(32'h000082FF, 4'h1);
    rd(8'h24, 32'h00FF000C);
    apb(1'b1, 8'h04, 32'hFFFFF123);
    ex(32'h00004014, 4'h1);
    rd(8'h24, 32'h0123000C);
    apb(1'b1, 8'h0C, 32'h00001000);
    ex(32'h00008C10, 4'h1);
    rd(8'h30, 32'h00001020);
    ex(32'h00008EF0, 4'h1);
    rd(8'h2C, 32'h00000FE0);
    maddr = 32'h00000100;
    apb(1'b1, 8'h04, maddr);
    apb(1'b1, 8'h14, mem_q);
    ex(32'h00004157, 4'h3);
    rd(8'h28, mem_q);
    rd(8'h50, 32'h00000104);
    apb(1'b1, 8'h08, 32'h00000200);
    ex(32'h00004153, 4'h2);
    rd(8'h54, 32'h000001FC);
    rd(8'h58, mem_q);
    apb(1'b1, 8'h34, 32'h00000055);
    ex(32'h0000036A, 4'h1);
    rd(8'h4C, 32'h00000055);
    apb(1'b1, 8'h10, 32'h00000400);
    apb(1'b1, 8'h20, 32'h00000001);
    ex(32'h0000C305, 4'h7);
    rd(8'h54, 32'h00000414);
    apb(1'b1, 8'h20, 32'h00000000);
    ex(32'h0000FFFF, 4'h1);
    chk(32'(r[1]), 32'h00000001);
    apb(1'b0, 8'h6C, 32'h0);
    chk(32'(err), 32'h00000001);
    apb(1'b1, 8'h14, 32'h00000402);
    ex(32'h0000C305, 4'h7);
    rd(8'h5C, 32'h00000402);
    apb(1'b1, 8'h14, 32'h00000400);
    ex(32'h0000C305, 4'h6);
    rd(8'h58, 32'h0123000C);
    rd(8'h50, 32'h000001F8);
    apb(1'b1, 8'h20, 32'h00000002);
    ex(32'h00004157, 4'h4);
    apb(1'b1, 8'h20, 32'h00000000);
    ex(32'h0000405E, 4'h1);
    rd(8'h28, 32'h00000100);
    ex(32'h0000407A, 4'h1);
    ex(32'h00004072, 4'h1);
    rd(8'h58, 32'h00000100);
    ex(32'h00000052, 4'h1);
    rd(8'h4C, 32'h00000100);
    apb(1'b1, 8'h04, 32'h10000010);
    apb(1'b1, 8'h08, 32'h10010020);
    apb(1'b1, 8'h1C, 32'h00000020);
    ex(32'h0000F00B, 4'h1);
    chk(32'(r[9:7]), 32'h00000006);
    rd(8'h50, 32'h10000012);
    rd(8'h68, 32'h10010040);
    apb(1'b1, 8'h08, 32'h20000000);
    ex(32'hF8020000, 4'h1);
    chk(32'(r[9:6]), 32'h0000000B);
    apb(1'b1, 8'h04, 32'h30000000);
    ex(32'h0000F60A, 4'h1);
    chk(32'({r[17:16], r[7], r[4]}), 32'h00000009);
    rd(8'h54, 32'h30000000);
    rd(8'h50, 32'h30000004);
    conclude();
  end
endmodule
